//--- pkg/pseq_pkg.sv
package pseq_pkg;

    localparam int unsigned WORD_W        = 32;
    localparam int unsigned SP_W          = 5;
    localparam int unsigned SEQ_MSB       = 31;
    localparam int unsigned SEQ_LSB       = 24;
    localparam int unsigned CLASS_MSB     = 31;
    localparam int unsigned CLASS_LSB     = 29;
    localparam int unsigned IMM5_MSB      = 28;
    localparam int unsigned IMM5_LSB      = 24;
    localparam int unsigned LONG_CALL_BIT = 28;
    localparam int unsigned LONG_OP_MSB   = 27;
    localparam int unsigned LONG_OP_LSB   = 24;
    localparam int unsigned DISP24_MSB    = 23;
    localparam int unsigned DISP28_MSB    = 27;
    localparam int unsigned TRAP_IMM_MSB  = 10;

    localparam logic [2:0] CLS_MISC  = 3'h0;
    localparam logic [2:0] CLS_SHBR  = 3'h1;
    localparam logic [2:0] CLS_BRC   = 3'h2;
    localparam logic [2:0] CLS_FBR   = 3'h3;
    localparam logic [2:0] CLS_SHSOB = 3'h4;
    localparam logic [2:0] CLS_LONG  = 3'h7;

    localparam logic [4:0] MISC_BRSTKP  = 5'h01;
    localparam logic [4:0] MISC_BSRSTK  = 5'h02;
    localparam logic [4:0] MISC_RTS     = 5'h03;
    localparam logic [4:0] MISC_LOOP    = 5'h04;
    localparam logic [4:0] MISC_ENDLOOP = 5'h05;
    localparam logic [4:0] MISC_FNDLOOP = 5'h06;
    localparam logic [4:0] MISC_OVNEUT  = 5'h07;
    localparam logic [4:0] MISC_OVNEUTI = 5'h08;
    localparam logic [4:0] MISC_REVNEUT = 5'h09;

    localparam logic [3:0] LONG_BRANCH  = 4'h0;
    localparam logic [3:0] LONG_SOB     = 4'h1;
    localparam logic [3:0] LONG_BRP     = 4'h2;
    localparam logic [3:0] LONG_TRAPI   = 4'h3;
    localparam logic [3:0] LONG_RTI     = 4'h4;
    localparam logic [3:0] LONG_SETUSER = 4'h5;

    localparam logic [WORD_W-1:0] RESET_ADDR   = 32'h00000000;
    localparam logic [WORD_W-1:0] ADDR_STEP    = 32'h00000001;
    localparam logic [SP_W-1:0]   SP_RESET     = 5'h1F;
    localparam logic [SP_W-1:0]   SP_EMPTY     = 5'h1F;
    localparam logic [SP_W-1:0]   SP_NEAR_FULL = 5'h1D;
    localparam logic [SP_W-1:0]   SP_ONE       = 5'h01;

    typedef enum logic [4:0] {
        OP_NOP, OP_SHBR, OP_BRC, OP_FBR, OP_SHSOB, OP_BRSTKP, OP_BSRSTK,
        OP_RTS, OP_LOOP, OP_ENDLOOP, OP_FNDLOOP, OP_OVNEUT, OP_OVNEUTI,
        OP_REVNEUT, OP_BRANCH, OP_BSR, OP_SOB, OP_BRP, OP_TRAPI, OP_RTI,
        OP_SETUSER
    } pseq_op_type;

endpackage

//--- verilog/pseq_stack_ram.sv
`timescale 1ns/1ps
`default_nettype none
module pseq_stack_ram
    import pseq_pkg::*;
#(
    parameter int unsigned ADDR_W = 5,
    parameter int unsigned DATA_W = 32
) (
    input  wire logic              clk_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Write-through keeps a pop right after a push coherent.
    always_ff @(posedge clk_in) begin
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            rd_data_out <= wr_data_in;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule
`default_nettype wire

//--- verilog/pseq_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module pseq_decoder
    import pseq_pkg::*;
(
    input  wire logic [WORD_W-1:0] instr_in,
    output pseq_op_type            op_out,
    output logic [WORD_W-1:0]      imm_out,
    output logic                   long_fmt_out,
    output logic                   priv_out
);

    logic [2:0] cls;
    logic [4:0] imm5;
    logic [3:0] lop;

    always_comb begin
        cls          = instr_in[CLASS_MSB:CLASS_LSB];
        imm5         = instr_in[IMM5_MSB:IMM5_LSB];
        lop          = instr_in[LONG_OP_MSB:LONG_OP_LSB];
        op_out       = OP_NOP;
        imm_out      = '0;
        long_fmt_out = (cls == CLS_LONG);
        priv_out     = 1'b0;
        case (cls)
            CLS_SHBR: begin
                op_out  = OP_SHBR;
                imm_out = {{27{imm5[4]}}, imm5};
            end
            CLS_BRC: begin
                op_out  = OP_BRC;
                imm_out = {27'h0000000, imm5};
            end
            CLS_FBR: begin
                op_out  = OP_FBR;
                imm_out = {27'h0000000, imm5};
            end
            CLS_SHSOB: begin
                op_out  = OP_SHSOB;
                imm_out = {27'h7FFFFFF, imm5};
            end
            CLS_MISC: begin
                case (imm5)
                    MISC_BRSTKP:  op_out = OP_BRSTKP;
                    MISC_BSRSTK:  op_out = OP_BSRSTK;
                    MISC_RTS:     op_out = OP_RTS;
                    MISC_LOOP:    op_out = OP_LOOP;
                    MISC_ENDLOOP: op_out = OP_ENDLOOP;
                    MISC_FNDLOOP: op_out = OP_FNDLOOP;
                    MISC_OVNEUT:  op_out = OP_OVNEUT;
                    MISC_OVNEUTI: op_out = OP_OVNEUTI;
                    MISC_REVNEUT: op_out = OP_REVNEUT;
                    default:      op_out = OP_NOP;
                endcase
            end
            CLS_LONG: begin
                if (instr_in[LONG_CALL_BIT]) begin
                    op_out  = OP_BSR;
                    imm_out = {{4{instr_in[DISP28_MSB]}}, instr_in[DISP28_MSB:0]};
                end else begin
                    imm_out = {{8{instr_in[DISP24_MSB]}}, instr_in[DISP24_MSB:0]};
                    case (lop)
                        LONG_BRANCH: op_out = OP_BRANCH;
                        LONG_SOB:    op_out = OP_SOB;
                        LONG_BRP:    op_out = OP_BRP;
                        LONG_TRAPI: begin
                            op_out  = OP_TRAPI;
                            imm_out = {21'h000000, instr_in[TRAP_IMM_MSB:0]};
                        end
                        LONG_RTI: begin
                            op_out   = OP_RTI;
                            priv_out = 1'b1;
                        end
                        LONG_SETUSER: begin
                            op_out   = OP_SETUSER;
                            priv_out = 1'b1;
                        end
                        default:     op_out = OP_NOP;
                    endcase
                end
            end
            default: op_out = OP_NOP;
        endcase
    end

endmodule
`default_nettype wire

//--- verilog/pseq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pseq_sequencer
    import pseq_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic [WORD_W-1:0] instr_in,
    input  wire logic              int_cond_in,
    input  wire logic              fp_cond_in,
    input  wire logic              irq_take_in,
    input  wire logic [WORD_W-1:0] irq_vector_in,
    output logic      [WORD_W-1:0] fetch_addr_out,
    output logic      [WORD_W-1:0] exec_addr_out,
    output logic                   exec_commit_out,
    output logic                   int_issue_out,
    output logic                   supervisor_out,
    output logic                   trap_req_out,
    output logic                   priv_viol_out,
    output logic                   stack_near_ovf_out,
    output logic                   stack_near_unf_out,
    output logic      [WORD_W-1:0] stack_top_out,
    output logic      [SP_W-1:0]   stack_ptr_out
);

    // ****************************************
    // Pipeline state.
    // ****************************************
    logic [WORD_W-1:0] cfa;
    logic [WORD_W-1:0] cea;
    logic              exec_valid;
    logic              neut_now;
    logic              ovr_armed;
    logic              rev_armed;
    logic              sup;
    logic              prev_sup;
    logic [WORD_W-1:0] tos;
    logic [SP_W-1:0]   sp;

    // ****************************************
    // Decode.
    // ****************************************
    pseq_op_type       op;
    logic [WORD_W-1:0] imm;
    logic              long_fmt;
    logic              priv;

    // The decoder works on the word now on instr_in.
    pseq_decoder u_decoder (
        .instr_in     (instr_in),
        .op_out       (op),
        .imm_out      (imm),
        .long_fmt_out (long_fmt),
        .priv_out     (priv)
    );

    // ****************************************
    // Execute qualification.
    // ****************************************
    logic              run;
    logic              priv_fault;
    logic              act;
    logic [WORD_W-1:0] next_addr;
    logic [WORD_W-1:0] tos_dec;

    // A neutralized shadow, an honoured interrupt or a privilege fault drops the word.
    // A dropped word takes no branch and leaves the stack alone.
    always_comb begin
        run        = exec_valid && !neut_now && !irq_take_in;
        priv_fault = run && priv && !sup;
        act        = run && !priv_fault;
        next_addr  = cea + ADDR_STEP;
        tos_dec    = tos - ADDR_STEP;
    end

    assign exec_commit_out = act;
    assign int_issue_out   = act && !long_fmt;

    // ****************************************
    // Control transfer and stack effects.
    // ****************************************
    logic              taken;
    logic              cond_op;
    logic [WORD_W-1:0] target;
    logic              do_push;
    logic              do_pop;
    logic              do_mod;
    logic              do_bump;
    logic [WORD_W-1:0] stk_val;

    // Relative targets start from the executing address, never from the fetching one.
    always_comb begin
        taken   = 1'b0;
        cond_op = 1'b0;
        target  = cea + imm;
        do_push = 1'b0;
        do_pop  = 1'b0;
        do_mod  = 1'b0;
        do_bump = 1'b0;
        stk_val = next_addr;
        if (act) begin
            case (op)
                OP_SHBR: begin
                    taken = 1'b1;
                end
                OP_BRC: begin
                    cond_op = 1'b1;
                    taken   = int_cond_in;
                end
                OP_FBR: begin
                    cond_op = 1'b1;
                    taken   = fp_cond_in;
                end
                OP_BRANCH: begin
                    taken = 1'b1;
                end
                OP_BRSTKP: begin
                    taken  = 1'b1;
                    target = cea + tos;
                    do_pop = 1'b1;
                end
                OP_BSR: begin
                    taken   = 1'b1;
                    do_push = 1'b1;
                end
                OP_BSRSTK: begin
                    taken  = 1'b1;
                    target = tos;
                    do_mod = 1'b1;
                end
                OP_RTS, OP_RTI: begin
                    taken  = 1'b1;
                    target = tos;
                    do_pop = 1'b1;
                end
                OP_LOOP: begin
                    do_push = 1'b1;
                end
                OP_ENDLOOP, OP_FNDLOOP: begin
                    cond_op = 1'b1;
                    taken   = (op == OP_ENDLOOP) ? int_cond_in : fp_cond_in;
                    target  = tos;
                    do_pop  = !taken;
                end
                OP_SOB, OP_SHSOB: begin
                    cond_op = 1'b1;
                    taken   = (tos_dec != '0);
                    do_mod  = taken;
                    do_pop  = !taken;
                    stk_val = tos_dec;
                end
                OP_BRP: begin
                    taken  = 1'b1;
                    do_pop = 1'b1;
                end
                OP_TRAPI: begin
                    do_push = 1'b1;
                    stk_val = imm;
                end
                OP_OVNEUTI: begin
                    do_bump = 1'b1;
                end
                default: begin
                    taken = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Program counters.
    // ****************************************
    logic [WORD_W-1:0] next_cfa;

    // The fetch counter runs one word ahead, so a target word arrives a cycle late.
    always_comb begin
        if (irq_take_in) begin
            next_cfa = irq_vector_in;
        end else if (taken) begin
            next_cfa = target;
        end else begin
            next_cfa = cfa + ADDR_STEP;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cfa        <= RESET_ADDR;
            cea        <= RESET_ADDR;
            exec_valid <= 1'b0;
        end else begin
            cfa        <= next_cfa;
            cea        <= cfa;
            exec_valid <= 1'b1;
        end
    end

    assign fetch_addr_out = cfa;
    assign exec_addr_out  = cea;

    // ****************************************
    // Shadow neutralization.
    // ****************************************
    logic branch_op;
    logic next_neut;

    // An armed override or reversal is spent on the next branch-type op.
    // An interrupt always drops the shadow, whatever was armed.
    always_comb begin
        branch_op = taken || cond_op;
        if (irq_take_in) begin
            next_neut = 1'b1;
        end else if (branch_op && rev_armed) begin
            next_neut = !taken;
        end else if (taken) begin
            next_neut = !ovr_armed;
        end else begin
            next_neut = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            neut_now <= 1'b0;
        end else begin
            neut_now <= next_neut;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ovr_armed <= 1'b0;
            rev_armed <= 1'b0;
        end else if (act && (op == OP_OVNEUT || op == OP_OVNEUTI)) begin
            ovr_armed <= 1'b1;
            rev_armed <= 1'b0;
        end else if (act && op == OP_REVNEUT) begin
            ovr_armed <= 1'b0;
            rev_armed <= 1'b1;
        end else if (branch_op || irq_take_in) begin
            ovr_armed <= 1'b0;
            rev_armed <= 1'b0;
        end
    end

    // ****************************************
    // Supervisor mode.
    // ****************************************
    // The mode in force when an interrupt is honoured is kept for its return.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sup      <= 1'b1;
            prev_sup <= 1'b1;
        end else if (irq_take_in) begin
            sup      <= 1'b1;
            prev_sup <= sup;
        end else if (act && op == OP_RTI) begin
            sup <= prev_sup;
        end else if (act && op == OP_SETUSER) begin
            sup <= 1'b0;
        end
    end

    assign supervisor_out = sup;

    // ****************************************
    // Stack.
    // ****************************************
    logic [SP_W-1:0]   next_sp;
    logic [WORD_W-1:0] next_tos;
    logic              ram_we;
    logic [SP_W-1:0]   ram_wa;
    logic [WORD_W-1:0] ram_rd;

    // A push parks the old top one word above the pointer.
    // The RAM reads the word at the next pointer, so a pop finds it at once.
    // Reset keeps the RAM from being written and points it at the empty stack.
    always_comb begin
        next_sp  = sp;
        next_tos = tos;
        ram_we   = 1'b0;
        ram_wa   = sp + SP_ONE;
        if (reset_in) begin
            next_sp = SP_RESET;
        end else if (do_push) begin
            ram_we   = 1'b1;
            next_sp  = sp + SP_ONE;
            next_tos = stk_val;
        end else if (do_pop) begin
            next_sp  = sp - SP_ONE;
            next_tos = ram_rd;
        end else if (do_mod) begin
            next_tos = stk_val;
        end else if (do_bump) begin
            next_sp = sp + SP_ONE;
        end
    end

    pseq_stack_ram #(
        .ADDR_W (SP_W),
        .DATA_W (WORD_W)
    ) u_stack_ram (
        .clk_in      (clk_in),
        .wr_en_in    (ram_we),
        .wr_addr_in  (ram_wa),
        .wr_data_in  (tos),
        .rd_addr_in  (next_sp),
        .rd_data_out (ram_rd)
    );

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sp  <= SP_RESET;
            tos <= '0;
        end else begin
            sp  <= next_sp;
            tos <= next_tos;
        end
    end

    assign stack_top_out = tos;
    assign stack_ptr_out = sp;

    // ****************************************
    // Event pulses.
    // ****************************************
    // Each event flag stands for the one cycle after its cause.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            trap_req_out       <= 1'b0;
            priv_viol_out      <= 1'b0;
            stack_near_ovf_out <= 1'b0;
            stack_near_unf_out <= 1'b0;
        end else begin
            trap_req_out       <= act && op == OP_TRAPI;
            priv_viol_out      <= priv_fault;
            stack_near_ovf_out <= do_push && next_sp == SP_NEAR_FULL;
            stack_near_unf_out <= do_pop && next_sp == SP_EMPTY;
        end
    end

endmodule
`default_nettype wire

//--- bench/pseq_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Code memory that answers one cycle late.
// ****************************************
module pseq_code_mem
    import pseq_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [WORD_W-1:0] addr_in,
    output logic      [WORD_W-1:0] word_out
);
    logic [WORD_W-1:0] words [64];

    always_ff @(posedge clk_in) begin
        word_out <= words[addr_in[5:0]];
    end
endmodule
`default_nettype wire

//--- bench/pseq_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks of the sequencer.
// ****************************************
module pseq_sequencer_props
    import pseq_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              reset_in,
    input wire logic [WORD_W-1:0] instr_in,
    input wire logic              irq_take_in,
    input wire logic [WORD_W-1:0] fetch_addr_out,
    input wire logic [WORD_W-1:0] exec_addr_out,
    input wire logic              exec_commit_out,
    input wire logic              int_issue_out,
    input wire logic              supervisor_out,
    input wire logic              trap_req_out,
    input wire logic              priv_viol_out,
    input wire logic              stack_near_unf_out,
    input wire logic [WORD_W-1:0] stack_top_out,
    input wire logic [SP_W-1:0]   stack_ptr_out
);
    logic             armed;
    wire logic [2:0]  cls   = instr_in[31:29];
    wire logic [31:0] sdisp = {{27{instr_in[28]}}, instr_in[28:24]};
    wire logic [31:0] ldisp = {{8{instr_in[23]}}, instr_in[23:0]};
    wire logic [10:0] imm11 = instr_in[10:0];
    wire logic        user_priv = !supervisor_out && instr_in[31:24] inside {8'hE4, 8'hE5};

    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Tracks a pending shadow override or reversal so that plain branches can be judged.
    always_ff @(posedge clk_in) begin
        if (reset_in || irq_take_in) begin
            armed <= 1'b0;
        end else if (exec_commit_out && cls == 3'h0
                     && instr_in[28:24] inside {5'h07, 5'h08, 5'h09}) begin
            armed <= 1'b1;
        end else if (exec_commit_out && cls != 3'h0 && cls < 3'h5) begin
            armed <= 1'b0;
        end
    end

    a_exec_follows: assert property (
        1'b1 |=> exec_addr_out == $past(fetch_addr_out))
        else $error("executing address is not the previous fetch address");
    a_short_target: assert property (
        exec_commit_out && cls == 3'h1
        |=> fetch_addr_out == $past(exec_addr_out) + $past(sdisp))
        else $error("short branch target wrong");
    a_long_target: assert property (
        exec_commit_out && instr_in[31:24] == 8'hE0
        |=> fetch_addr_out == $past(exec_addr_out) + $past(ldisp))
        else $error("long branch target wrong");
    a_shadow_noop: assert property (
        exec_commit_out && cls == 3'h1 && !armed |=> !exec_commit_out)
        else $error("shadow instruction executed");
    a_call_push: assert property (
        exec_commit_out && instr_in[31:28] == 4'hF && !armed
        |=> stack_top_out == $past(exec_addr_out) + 32'h00000001
            && stack_ptr_out == $past(stack_ptr_out) + 5'h01)
        else $error("call did not push the next address");
    a_issue_format: assert property (
        int_issue_out == (exec_commit_out && cls != 3'h7))
        else $error("integer issue disagrees with format");
    a_trap_push: assert property (
        exec_commit_out && instr_in[31:24] == 8'hE3
        |=> trap_req_out && stack_top_out == {21'h000000, $past(imm11)})
        else $error("trap did not push or signal");
    a_priv_block: assert property (user_priv |-> !exec_commit_out)
        else $error("privileged op ran in user mode");
    a_priv_flag: assert property (priv_viol_out |-> $past(user_priv))
        else $error("privilege violation without a privileged op");
    a_irq_super: assert property (irq_take_in |=> supervisor_out)
        else $error("interrupt left user mode");
    a_unf_flag: assert property (
        stack_ptr_out == 5'h1F && $past(stack_ptr_out) == 5'h00 |-> ##[0:1] stack_near_unf_out)
        else $error("emptying pop not flagged");

    c_short_branch: cover property (exec_commit_out && cls == 3'h1);
    c_trap: cover property (trap_req_out);
    c_priv: cover property (priv_viol_out);
endmodule

bind pseq_sequencer pseq_sequencer_props u_props (
    .clk_in(clk_in), .reset_in(reset_in), .instr_in(instr_in), .irq_take_in(irq_take_in),
    .fetch_addr_out(fetch_addr_out), .exec_addr_out(exec_addr_out),
    .exec_commit_out(exec_commit_out), .int_issue_out(int_issue_out),
    .supervisor_out(supervisor_out), .trap_req_out(trap_req_out),
    .priv_viol_out(priv_viol_out), .stack_near_unf_out(stack_near_unf_out),
    .stack_top_out(stack_top_out), .stack_ptr_out(stack_ptr_out)
);
`default_nettype wire

//--- bench/pseq_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Sequencer bench.
// ****************************************
module pseq_sequencer_test import pseq_pkg::*;;
    typedef struct {
        logic [7:0]  p;
        logic [31:0] ins;
        logic [2:0]  f;
        logic [31:0] adr;
        logic [4:0]  sp;
        logic [7:0]  top;
    } pseq_row_type;

    logic        clk_in   = 1'b0;
    logic        reset_in = 1'b1;
    logic        int_cond = 1'b0;
    logic        fp_cond  = 1'b0;
    logic        irq_take = 1'b0;
    logic [31:0] irq_vec  = 32'h00000028;
    logic [31:0] instr;
    logic [31:0] fetch;
    logic [31:0] exec_addr;
    logic [31:0] top;
    logic [4:0]  sp;
    logic        commit;
    logic        issue;
    logic        sup;
    logic        trap;
    logic        priv;
    logic        ovf;
    logic        unf;
    int          errors = 0;
    int          checks = 0;

    // Fields: prelude byte, instruction, {int, fp, shadow runs}, next address, pointer, top.
    pseq_row_type rows [21] = '{
        '{8'h04, 32'hE0000020, 3'h0, 32'h00000021, 5'h00, 8'h01},
        '{8'h04, 32'h30000000, 3'h0, 32'hFFFFFFF1, 5'h00, 8'h01},
        '{8'h04, 32'h5F000000, 3'h4, 32'h00000020, 5'h00, 8'h01},
        '{8'h04, 32'h63000000, 3'h2, 32'h00000004, 5'h00, 8'h01},
        '{8'h04, 32'h63000000, 3'h5, 32'h00000003, 5'h00, 8'h01},
        '{8'h04, 32'h01000000, 3'h0, 32'h00000002, 5'h1F, 8'h00},
        '{8'h04, 32'h02000000, 3'h0, 32'h00000001, 5'h00, 8'h02},
        '{8'h04, 32'h03000000, 3'h0, 32'h00000001, 5'h1F, 8'h00},
        '{8'h04, 32'h04000000, 3'h1, 32'h00000003, 5'h01, 8'h02},
        '{8'h04, 32'h05000000, 3'h4, 32'h00000001, 5'h00, 8'h01},
        '{8'h04, 32'h05000000, 3'h1, 32'h00000003, 5'h1F, 8'h00},
        '{8'h04, 32'h06000000, 3'h2, 32'h00000001, 5'h00, 8'h01},
        '{8'hE3, 32'hE1000005, 3'h0, 32'h00000006, 5'h00, 8'h04},
        '{8'h04, 32'hE1000005, 3'h1, 32'h00000003, 5'h1F, 8'h00},
        '{8'hE3, 32'h9E000000, 3'h0, 32'hFFFFFFFF, 5'h00, 8'h04},
        '{8'h04, 32'hE2000004, 3'h0, 32'h00000005, 5'h1F, 8'h00},
        '{8'h04, 32'hFFFFFFF0, 3'h0, 32'hFFFFFFF1, 5'h01, 8'h02},
        '{8'h07, 32'h2F000000, 3'h1, 32'h00000010, 5'h1F, 8'h00},
        '{8'h08, 32'h2F000000, 3'h1, 32'h00000010, 5'h00, 8'h00},
        '{8'h09, 32'h5F000000, 3'h0, 32'h00000003, 5'h1F, 8'h00},
        '{8'h09, 32'h2F000000, 3'h1, 32'h00000010, 5'h1F, 8'h00}
    };

    pseq_code_mem mem (.clk_in(clk_in), .addr_in(fetch), .word_out(instr));

    pseq_sequencer dut (
        .clk_in(clk_in), .reset_in(reset_in), .instr_in(instr), .int_cond_in(int_cond),
        .fp_cond_in(fp_cond), .irq_take_in(irq_take), .irq_vector_in(irq_vec),
        .fetch_addr_out(fetch), .exec_addr_out(exec_addr), .exec_commit_out(commit),
        .int_issue_out(issue), .supervisor_out(sup), .trap_req_out(trap),
        .priv_viol_out(priv), .stack_near_ovf_out(ovf), .stack_near_unf_out(unf),
        .stack_top_out(top), .stack_ptr_out(sp)
    );

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic wrap_up();
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for the address, pointer or near-overflow flag to reach a value.
    task automatic wait_for(input int k, input logic [31:0] v);
        logic [31:0] s;
        for (int n = 0; n < 64; n++) begin
            s = (k == 0) ? exec_addr : (k == 1) ? 32'(sp) : 32'(ovf);
            if (s === v) begin
                return;
            end
            @(negedge clk_in);
        end
        errors++;
        wrap_up();
    endtask

    task automatic restart();
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
    endtask

    task automatic run_row(input pseq_row_type r);
        {int_cond, fp_cond} = r.f[2:1];
        mem.words[0] = {r.p, 24'h000005};
        mem.words[1] = r.ins;
        restart();
        wait_for(0, 32'h00000001);
        check("issue", 32'(issue), 32'(r.ins[31:29] != 3'h7));
        @(negedge clk_in);
        check("shadow", 32'(commit), 32'(r.f[0]));
        check("near_unf", 32'(unf), 32'(r.sp == 5'h1F && r.p == 8'h04));
        @(negedge clk_in);
        check("exec_addr", exec_addr, r.adr);
        check("stack_ptr", 32'(sp), 32'(r.sp));
        check("stack_top", top, 32'(r.top));
    endtask

    initial begin
        for (int i = 0; i < 64; i++) begin
            mem.words[i] = 32'h00000000;
        end
        repeat (16) @(negedge clk_in);
        check("fetch", fetch, 32'h00000000);
        check("sup", 32'(sup), 32'h00000001);
        check("ptr", 32'(sp), 32'h0000001F);
        reset_in = 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        {int_cond, fp_cond} = 2'h0;
        mem.words[0] = 32'hE5000000;
        mem.words[1] = 32'hE5000000;
        mem.words[2] = 32'hE3000007;
        mem.words[40] = 32'hE4000000;
        restart();
        wait_for(0, 32'h00000001);
        check("user", 32'(sup), 32'h00000000);
        check("blocked", 32'(commit), 32'h00000000);
        @(negedge clk_in);
        check("priv", 32'(priv), 32'h00000001);
        @(negedge clk_in);
        check("trap", 32'(trap), 32'h00000001);
        check("trap_top", top, 32'h00000007);
        irq_take = 1'b1;
        @(negedge clk_in);
        irq_take = 1'b0;
        check("irq_sup", 32'(sup), 32'h00000001);
        wait_for(0, 32'h00000028);
        wait_for(0, 32'h00000007);
        check("restored", 32'(sup), 32'h00000000);
        for (int i = 0; i < 40; i++) begin
            mem.words[i] = 32'h04000000;
        end
        restart();
        wait_for(2, 32'h00000001);
        wait_for(1, 32'h00000000);
        wrap_up();
    end
endmodule
`default_nettype wire
